// ===== hw/csfcr_top.sv
// codec serial port framing, bit clock and reset with AXI4-Lite registers
`include "csfcr_regs.svh"

module csfcr_top
  import csfcr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             shift_clk,
  output logic             rx_frame_sync,
  output logic             rx_serial_line,
  output logic             tx_frame_sync,
  input  wire logic        tx_serial_line,
  output logic             aux_bit_eleven_pin
);

  // --------------------------------------------------------------------------
  // registers and internal signals
  // --------------------------------------------------------------------------
  logic [11:0]   ctrl;
  csfcr_div_s    div_q [2];
  logic [7:0]    tweak [2];
  logic          dual_word;
  logic [15:0]   rx_word;
  logic          rx_valid;
  logic          overrun;
  logic          underrun;

  logic [1:0]    phase;
  logic          fall_ev;
  logic          rise_ev;
  logic [1:0]    sin_sync;
  logic          sin_s;

  logic [1:0]    wrap;
  logic [1:0]    pend;
  logic [1:0]    start;
  logic [1:0]    done;
  logic [1:0]    fs;
  csfcr_frame_e  st     [2];
  logic [3:0]    bitcnt [2];
  logic [15:0]   sh     [2];

  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [15:0]   fifo_out_data;

  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          do_write;
  logic          wr_txw;
  logic          wr_status;
  logic          rd_rxw;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return (old & ~m) | (nw & m);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    logic [7:0] k;
    k = a & `CSFCR_ADDR_MASK;
    return k == `CSFCR_OFF_CTRL    || k == `CSFCR_OFF_TX_DIV  ||
           k == `CSFCR_OFF_RX_DIV  || k == `CSFCR_OFF_TWEAK   ||
           k == `CSFCR_OFF_MODE    || k == `CSFCR_OFF_TX_WORD ||
           k == `CSFCR_OFF_RX_WORD || k == `CSFCR_OFF_STATUS;
  endfunction

  // --------------------------------------------------------------------------
  // bit clock: master clock divided by four, high while in reset
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign fall_ev = phase == `CSFCR_FALL_PHASE;
  assign rise_ev = phase == `CSFCR_RISE_PHASE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_clk <= 1'b1;
    end else if (fall_ev) begin
      shift_clk <= 1'b0;
    end else if (rise_ev) begin
      shift_clk <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sin_sync <= 2'b00;
    end else begin
      sin_sync <= {sin_sync[0], tx_serial_line};
    end
  end

  assign sin_s = sin_sync[1];

  // --------------------------------------------------------------------------
  // frame engines: channel 0 sends samples out, channel 1 takes words in
  // --------------------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_frame
    csfcr_rate_div u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .div     (div_q[ch]),
      .wrap    (wrap[ch])
    );

    assign start[ch] = fall_ev & pend[ch] & (st[ch] == CSFCR_IDLE);
    assign done[ch]  = rise_ev & (st[ch] == CSFCR_SHIFT) &
                       (bitcnt[ch] == `CSFCR_LAST_BIT);

    // pending from reset so that traffic begins at once
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pend[ch] <= 1'b1;
      end else if (wrap[ch]) begin
        pend[ch] <= 1'b1;
      end else if (start[ch]) begin
        pend[ch] <= 1'b0;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        st[ch]     <= CSFCR_IDLE;
        fs[ch]     <= 1'b1;
        bitcnt[ch] <= 4'h0;
        sh[ch]     <= 16'h0000;
      end else begin
        unique case (st[ch])
          CSFCR_IDLE: begin
            if (start[ch]) begin
              st[ch] <= CSFCR_LEAD;
              // msb goes out on a falling edge, before the sync drops
              if (ch == 0 && fifo_out_valid) begin
                sh[ch] <= fifo_out_data;
              end else begin
                sh[ch] <= 16'h0000;
              end
            end
          end
          CSFCR_LEAD: begin
            if (rise_ev) begin
              st[ch]     <= CSFCR_SHIFT;
              fs[ch]     <= 1'b0;
              bitcnt[ch] <= 4'h0;
            end
          end
          CSFCR_SHIFT: begin
            if (rise_ev) begin
              sh[ch] <= {sh[ch][14:0], (ch == 1) ? sin_s : 1'b0};
              if (bitcnt[ch] == `CSFCR_LAST_BIT) begin
                st[ch] <= CSFCR_IDLE;
                fs[ch] <= 1'b1;
              end else begin
                bitcnt[ch] <= bitcnt[ch] + 4'h1;
              end
            end
          end
          default: begin
            st[ch] <= CSFCR_IDLE;
            fs[ch] <= 1'b1;
          end
        endcase
      end
    end
  end

  assign rx_frame_sync  = fs[0];
  assign tx_frame_sync  = fs[1];
  assign rx_serial_line = sh[0][15];

  // --------------------------------------------------------------------------
  // sample fifo toward the outgoing shifter
  // --------------------------------------------------------------------------
  csfcr_fifo #(
    .WIDTH (`CSFCR_WORD_W),
    .DEPTH (`CSFCR_FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (w_data[15:0]),
    .out_valid (fifo_out_valid),
    .out_ready (start[0]),
    .out_data  (fifo_out_data)
  );

  // --------------------------------------------------------------------------
  // captured words and sticky flags; a set beats a clear in the same cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_word  <= 16'h0000;
      rx_valid <= 1'b0;
      overrun  <= 1'b0;
      underrun <= 1'b0;
    end else begin
      if (done[1]) begin
        rx_word <= {sh[1][14:0], sin_s};
      end
      if (done[1]) begin
        rx_valid <= 1'b1;
      end else if (rd_rxw) begin
        rx_valid <= 1'b0;
      end
      if (done[1] && rx_valid && !rd_rxw) begin
        overrun <= 1'b1;
      end else if (wr_status && w_data[`CSFCR_ST_OVERRUN]) begin
        overrun <= 1'b0;
      end
      if (start[0] && !fifo_out_valid) begin
        underrun <= 1'b1;
      end else if (wr_status && w_data[`CSFCR_ST_UNDERRUN]) begin
        underrun <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_bit_eleven_pin <= 1'b0;
    end else begin
      aux_bit_eleven_pin <= dual_word & ctrl[`CSFCR_CTRL_AUX_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel: address and data taken in either order
  // --------------------------------------------------------------------------
  assign wr_txw   = (aw_addr & `CSFCR_ADDR_MASK) == `CSFCR_OFF_TX_WORD;
  // a full fifo stalls the write response, pushing back on software
  assign do_write = !s_axi_awready & !s_axi_wready & !s_axi_bvalid &
                    (!wr_txw | fifo_in_ready);
  assign fifo_in_valid = do_write & wr_txw & (|w_strb[1:0]);
  assign wr_status = do_write &
                     ((aw_addr & `CSFCR_ADDR_MASK) == `CSFCR_OFF_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= mapped(aw_addr) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= `CSFCR_CTRL_RST;
      div_q[0]  <= '{count_b: `CSFCR_DIV_B_RST, count_a: `CSFCR_DIV_A_RST};
      div_q[1]  <= '{count_b: `CSFCR_DIV_B_RST, count_a: `CSFCR_DIV_A_RST};
      tweak[0]  <= `CSFCR_TWEAK_RST;
      tweak[1]  <= `CSFCR_TWEAK_RST;
      dual_word <= 1'b0;
    end else if (do_write) begin
      unique case (aw_addr & `CSFCR_ADDR_MASK)
        `CSFCR_OFF_CTRL:
          ctrl <= 12'(merge({20'h0, ctrl}, w_data, w_strb));
        `CSFCR_OFF_TX_DIV:
          div_q[1] <= 16'(merge({16'h0, div_q[1]}, w_data, w_strb));
        `CSFCR_OFF_RX_DIV:
          div_q[0] <= 16'(merge({16'h0, div_q[0]}, w_data, w_strb));
        `CSFCR_OFF_TWEAK: begin
          if (w_strb[0]) tweak[1] <= w_data[7:0];
          if (w_strb[1]) tweak[0] <= w_data[15:8];
        end
        `CSFCR_OFF_MODE:
          if (w_strb[0]) dual_word <= w_data[0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  assign rd_rxw = s_axi_arvalid & s_axi_arready &
                  ((s_axi_araddr & `CSFCR_ADDR_MASK) == `CSFCR_OFF_RX_WORD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr & `CSFCR_ADDR_MASK)
        `CSFCR_OFF_CTRL:    s_axi_rdata <= {20'h0, ctrl};
        `CSFCR_OFF_TX_DIV:  s_axi_rdata <= {16'h0, div_q[1]};
        `CSFCR_OFF_RX_DIV:  s_axi_rdata <= {16'h0, div_q[0]};
        `CSFCR_OFF_TWEAK:   s_axi_rdata <= {16'h0, tweak[0], tweak[1]};
        `CSFCR_OFF_MODE:    s_axi_rdata <= {31'h0, dual_word};
        `CSFCR_OFF_RX_WORD: s_axi_rdata <= {15'h0, rx_valid, rx_word};
        `CSFCR_OFF_STATUS:
          s_axi_rdata <= {24'h0, fs[1], fs[0], !fifo_in_ready,
                          !fifo_out_valid, 1'b0, underrun, overrun,
                          rx_valid};
        default:            s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // csfcr_top

// ===== pkg/csfcr_regs.svh
// register map, reset values and timing constants of the codec serial framer
// Function
// - the bit clock is the master clock divided by four and times all serial transfers.
// - all timing (bit clock, frame rate) comes from integer divisions of the master clock.
// - the receive frame sync is driven low for the whole time outgoing sample bits shift out.
// - the most significant outgoing bit is on the receive serial line before its sync falls.
// - the transmit sync is driven low through the transfer; the host shifts in when it falls.
// - reset initialises all counters and the control register, then starts serial traffic.
// - after reset the dividers give a 16 kHz frame rate from a 10.368 MHz master clock.
// - reset loads both conversion-rate tweak registers with one.
// - reset clears control bits 11 and 10 and sets control bit 9.
// - reset sets control bits 7, 6, 5 and 2 and clears control bits 4 and 3.
// - the bit clock output is held high while reset is asserted.
// - in dual-word mode control bit 11 is driven onto the auxiliary pin one master clock later.
`ifndef CSFCR_REGS_SVH
`define CSFCR_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CSFCR_OFF_CTRL    8'h00
`define CSFCR_OFF_TX_DIV  8'h04
`define CSFCR_OFF_RX_DIV  8'h08
`define CSFCR_OFF_TWEAK   8'h0C
`define CSFCR_OFF_MODE    8'h10
`define CSFCR_OFF_TX_WORD 8'h14
`define CSFCR_OFF_RX_WORD 8'h18
`define CSFCR_OFF_STATUS  8'h1C
`define CSFCR_ADDR_MASK   8'hFC

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CSFCR_CTRL_RST    12'h2E4
`define CSFCR_DIV_A_RST   8'h12
`define CSFCR_DIV_B_RST   8'h12
`define CSFCR_TWEAK_RST   8'h01

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CSFCR_CTRL_AUX_BIT 11
`define CSFCR_ST_RX_VALID  0
`define CSFCR_ST_OVERRUN   1
`define CSFCR_ST_UNDERRUN  2

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CSFCR_MCLK_HZ      10368000
`define CSFCR_CONV_HZ      16000
`define CSFCR_SCLK_DIV     4
`define CSFCR_FALL_PHASE   2'h1
`define CSFCR_RISE_PHASE   2'h3
`define CSFCR_LAST_BIT     4'hF
`define CSFCR_MIN_PERIOD   17'h00080
`define CSFCR_WORD_W       16
`define CSFCR_FIFO_DEPTH   16

`endif

// ===== pkg/csfcr_pkg.sv
// types shared by the codec serial framer modules
package csfcr_pkg;

  typedef struct packed {
    logic [7:0] count_b;
    logic [7:0] count_a;
  } csfcr_div_s;

  typedef enum logic [1:0] {
    CSFCR_IDLE  = 2'b00,
    CSFCR_LEAD  = 2'b01,
    CSFCR_SHIFT = 2'b10
  } csfcr_frame_e;

endpackage

// ===== hw/csfcr_fifo.sv
// first-word-fall-through fifo with registered read data
module csfcr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW-1:0]    next_rd;
  logic [AW:0]      next_count;

  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign next_rd    = rd_ptr + AW'(pop);
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= wr_ptr + AW'(push);
      rd_ptr    <= next_rd;
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  // bypass covers a write into the slot that becomes the head
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data <= '0;
    end else if (push && wr_ptr == next_rd) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[next_rd];
    end
  end

endmodule // csfcr_fifo

// ===== hw/csfcr_rate_div.sv
// conversion-rate divider: one wrap pulse every 2*a*b master clocks, never fewer than 128
module csfcr_rate_div
  import csfcr_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  csfcr_div_s      div,
  output logic            wrap
);
  logic [16:0] cnt;
  logic [15:0] prod;
  logic [16:0] period;

  // a period shorter than one frame would overrun the shifter
  always_comb begin
    prod   = 16'(div.count_a) * 16'(div.count_b);
    period = {prod, 1'b0};
    if (period < `CSFCR_MIN_PERIOD) begin
      period = `CSFCR_MIN_PERIOD;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= '0;
      wrap <= 1'b0;
    end else if (cnt >= period - 17'h1) begin
      cnt  <= '0;
      wrap <= 1'b1;
    end else begin
      cnt  <= cnt + 17'h1;
      wrap <= 1'b0;
    end
  end

endmodule // csfcr_rate_div

// ===== test/csfcr_checker.sv
// concurrent checks on the codec serial framer ports
module csfcr_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic shift_clk,
  input wire logic rx_frame_sync,
  input wire logic rx_serial_line,
  input wire logic tx_frame_sync,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] rx_lo;
  logic [6:0] tx_lo;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------------------------------------------------------
  // low-time counters: sixteen bits span 64 master clocks
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_frame_sync) rx_lo <= 7'h00;
    else rx_lo <= rx_lo + 7'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_frame_sync) tx_lo <= 7'h00;
    else tx_lo <= tx_lo + 7'h01;
  end
  a_sclk_reset: assert property ($rose(aresetn) |-> shift_clk)
    else $error("bit clock low out of reset");
  a_sclk_ratio: assert property ($fell(shift_clk) |->
    ##1 !shift_clk ##1 shift_clk ##1 shift_clk ##1 !shift_clk)
    else $error("bit clock not master clock over four");
  a_start_rst: assert property ($rose(aresetn) |->
    ##[1:8] (!rx_frame_sync && !tx_frame_sync))
    else $error("no frame after reset");
  a_rx_sync_edge: assert property (
    $past(aresetn) && $changed(rx_frame_sync) |-> $rose(shift_clk))
    else $error("rx sync off bit clock edge");
  a_tx_sync_edge: assert property (
    $past(aresetn) && $changed(tx_frame_sync) |-> $rose(shift_clk))
    else $error("tx sync off bit clock edge");
  a_line_edge: assert property (
    $past(aresetn) && $changed(rx_serial_line) |-> $changed(shift_clk))
    else $error("rx line off bit clock edge");
  a_msb_before: assert property (
    $fell(rx_frame_sync) |-> $stable(rx_serial_line))
    else $error("first bit not ready before sync");
  a_rx_frame_len: assert property (
    $rose(rx_frame_sync) |-> rx_lo == 7'h40)
    else $error("rx frame not 64 clocks");
  a_rx_no_stretch: assert property (rx_lo <= 7'h40)
    else $error("rx frame too long");
  a_tx_frame_len: assert property (
    $rose(tx_frame_sync) |-> tx_lo == 7'h40)
    else $error("tx frame not 64 clocks");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // csfcr_checker

bind csfcr_top csfcr_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .shift_clk(shift_clk),
  .rx_frame_sync(rx_frame_sync), .rx_serial_line(rx_serial_line),
  .tx_frame_sync(tx_frame_sync), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ===== test/csfcr_host_model.sv
// behavioural host serial port facing the codec framer
module csfcr_host_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        shift_clk,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_serial_line,
  input  wire logic        tx_frame_sync,
  input  wire logic [15:0] host_word,
  output logic             tx_serial_line,
  output logic      [15:0] got_word,
  output logic             got_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sclk_q;
  logic [4:0]  rcnt;
  logic [4:0]  tcnt;
  logic [15:0] rsh;
  logic [15:0] tsh;
  // edges are seen one master clock late, which keeps the host
  // inside the one-cycle drive window after a rising bit clock
  always @(posedge aclk) begin
    sclk_q <= shift_clk;
    got_valid <= 1'b0;
    if (!aresetn || rx_frame_sync) begin
      rcnt <= 5'h00;
    end else if (sclk_q && !shift_clk && rcnt < 5'h10) begin
      rsh <= {rsh[14:0], rx_serial_line};
      rcnt <= rcnt + 5'h01;
      if (rcnt == 5'h0F) begin
        got_word <= {rsh[14:0], rx_serial_line};
        got_valid <= 1'b1;
      end
    end
    if (!aresetn) begin
      tcnt <= 5'h00;
      tx_serial_line <= 1'b0;
    end else if (tx_frame_sync) begin
      tcnt <= 5'h00;
      // a released line never keeps showing its last bit
      if (shift_clk && !sclk_q) tx_serial_line <= ~tx_serial_line;
    end else if (shift_clk && !sclk_q && tcnt < 5'h10) begin
      tx_serial_line <= (tcnt == 5'h00) ? host_word[15] : tsh[15];
      tsh <= ((tcnt == 5'h00) ? host_word : tsh) << 1;
      tcnt <= tcnt + 5'h01;
    end
  end
endmodule // csfcr_host_model

// ===== test/tb.sv
// self-checking bench for the codec serial framer
`include "csfcr_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        sclk, rfs, rline, tfs, tline, aux, gv;
  logic        rfs_q = 1'b1;
  logic [15:0] hword = 16'h0062, h2, gword, rnd = 16'h0062;
  logic [33:0] q_rd[$];
  logic [1:0]  q_b[$];
  logic [15:0] q_ser[$];
  logic [33:0] e_rd;
  logic [15:0] e_ser;
  logic [1:0]  e_b;
  int          miscompares = 0, cmp_count = 0;
  int          cyc = 0, last = 0, per = 0, nfall = 0;

  always #2 aclk = ~aclk;

  csfcr_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .shift_clk(sclk), .rx_frame_sync(rfs),
    .rx_serial_line(rline), .tx_frame_sync(tfs), .tx_serial_line(tline),
    .aux_bit_eleven_pin(aux));

  csfcr_host_model host (
    .aclk(aclk), .aresetn(aresetn), .shift_clk(sclk),
    .rx_frame_sync(rfs), .rx_serial_line(rline), .tx_frame_sync(tfs),
    .host_word(hword), .tx_serial_line(tline), .got_word(gword),
    .got_valid(gv));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    q_b.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    // a full fifo holds the answer back until the next frame start takes a word
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    input logic [31:0] ed);
    @(posedge aclk);
    q_rd.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // output watcher: oldest expectation against each result
  // --------------------------------------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    rfs_q <= rfs;
    if (rfs_q && !rfs) begin
      per <= cyc - last;
      last <= cyc;
      nfall <= nfall + 1;
    end
    if (rvalid && rready) begin
      e_rd = q_rd.pop_front();
      `CHK("read", e_rd, {rresp, rdata})
    end
    if (bvalid && bready) begin
      e_b = q_b.pop_front();
      `CHK("bresp", e_b, bresp)
    end
    // words sent once the fifo runs dry are underrun filler
    if (gv && q_ser.size() > 0) begin
      e_ser = q_ser.pop_front();
      `CHK("host word", e_ser, gword)
    end
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    q_ser.push_back(16'h0000);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CSFCR_OFF_CTRL, 2'b00, 32'h0000_02E4);
    rd(`CSFCR_OFF_TX_DIV, 2'b00, 32'h0000_1212);
    rd(`CSFCR_OFF_RX_DIV, 2'b00, 32'h0000_1212);
    rd(`CSFCR_OFF_TWEAK, 2'b00, 32'h0000_0101);
    rd(8'h20, 2'b10, 32'h0000_0000);
    wr(8'h24, 32'h0000_0001, 2'b10);
    h2 = lfsr(hword);
    hword <= h2;
    wr(`CSFCR_OFF_CTRL, 32'h0000_0AE4, 2'b00);
    repeat (2) @(posedge aclk);
    `CHK("aux", 1'b0, aux)
    wr(`CSFCR_OFF_MODE, 32'h0000_0001, 2'b00);
    repeat (2) @(posedge aclk);
    `CHK("aux", 1'b1, aux)
    wr(`CSFCR_OFF_CTRL, 32'h0000_02E4, 2'b00);
    repeat (2) @(posedge aclk);
    `CHK("aux", 1'b0, aux)
    for (int i = 0; i < 17; i++) begin
      rnd = lfsr(rnd);
      q_ser.push_back(rnd);
      wr(`CSFCR_OFF_TX_WORD, {16'h0000, rnd}, 2'b00);
    end
    wait (nfall == 2);
    repeat (72) @(posedge aclk);
    `CHK("period", 648, per)
    rd(`CSFCR_OFF_RX_WORD, 2'b00, {15'h0000, 1'b1, h2});
    rd(`CSFCR_OFF_STATUS, 2'b00, 32'h0000_00E6);
    wr(`CSFCR_OFF_STATUS, 32'h0000_0006, 2'b00);
    rd(`CSFCR_OFF_STATUS, 2'b00, 32'h0000_00E0);
    wr(`CSFCR_OFF_TX_DIV, 32'h0000_0808, 2'b00);
    wr(`CSFCR_OFF_RX_DIV, 32'h0000_0808, 2'b00);
    repeat (3000) @(posedge aclk);
    `CHK("period", 128, per)
    `CHK("left", 0, q_ser.size())
    end_of_test;
  end

  initial begin
    repeat (8000) @(posedge aclk);
    miscompares++;
    end_of_test;
  end
endmodule // tb
